// ==== rtl/ccsc_pkg.sv ====
package ccsc_pkg;
  localparam int CCSC_DW = 32;
  localparam int CCSC_AW = 4;
  // Register offsets (word addresses on the plain port)
  localparam logic [3:0] OFS_CTRL2 = 4'h0;
  localparam logic [3:0] OFS_COUNTER = 4'h1;
  localparam logic [3:0] OFS_PHASE = 4'h2;
  localparam logic [3:0] OFS_CAPTURE_REG_1 = 4'h3;
  localparam logic [3:0] OFS_CAPTURE_REG_2 = 4'h4;
  localparam logic [3:0] OFS_CAPTURE_REG_3 = 4'h5;
  localparam logic [3:0] OFS_CAPTURE_REG_4 = 4'h6;
  localparam logic [3:0] OFS_CTRL1 = 4'h7;
  // Control register two field positions (B_LDEN is a control register one bit)
  localparam int B_SINGLE = 0;
  localparam int B_WRAP_LO = 1;
  localparam int B_ARM = 3;
  localparam int B_RUN = 4;
  localparam int B_SYNCIN = 5;
  localparam int B_SYNCO_LO = 6;
  localparam int B_SOFTSYNC = 8;
  localparam int B_MODE = 9;
  localparam int B_POL = 10;
  localparam int B_LDEN = 8;
  localparam logic [1:0] WRAP_RST = 2'h3;
  localparam logic [15:0] CTRL2_RST = 16'h0006;

  typedef enum logic [1:0] {
    SYNCO_PASS = 2'b00,
    SYNCO_PRD = 2'b01,
    SYNCO_OFF2 = 2'b10,
    SYNCO_OFF3 = 2'b11
  } ccsc_synco_t;

  typedef struct packed {
    logic pwm_out_polarity;
    logic op_mode_select;
    ccsc_synco_t sync_out_source;
    logic sync_in_load_enable;
    logic timebase_run;
    logic [1:0] stop_wrap;
    logic single_run_select;
  } ccsc_ctrl_t;

  typedef struct packed {
    logic [CCSC_AW-1:0] addr;
    logic [CCSC_DW-1:0] wdata;
    logic wr;
    logic rd;
  } ccsc_bus_t;
endpackage

// ==== rtl/ccsc_slot_counter.sv ====
`timescale 1ns/1ns
// Two-bit event slot counter that wraps or stops at the stop/wrap compare
module ccsc_slot_counter
  import ccsc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic event_in,
  input wire logic arm,
  input wire logic single,
  input wire logic [1:0] stop_wrap,
  output logic [1:0] slot,
  output logic frozen,
  output logic load_ok
);
  logic [1:0] slot_q;
  logic frozen_q;
  logic hit;

  assign hit = (slot_q == stop_wrap);
  assign slot = slot_q;
  assign frozen = frozen_q;
  assign load_ok = !frozen_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      slot_q <= 2'h0;
      frozen_q <= 1'b0;
    end
    // RQ16 re-arm clears
    else if (arm)
    begin
      slot_q <= 2'h0;
      frozen_q <= 1'b0;
    end
    else if (event_in && !frozen_q)
    begin
      // RQ15 freeze on match
      if (hit && single)
        frozen_q <= 1'b1;
      else if (hit)
        slot_q <= 2'h0;
      else
        slot_q <= slot_q + 2'h1;
    end
  end
endmodule

// ==== rtl/ccsc_top.sv ====
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ns
// Functional notes
// RQ1 - Polarity bit inverts the PWM output only in auxiliary PWM mode; the code inverts it in both modes
// RQ2 - Capture mode: no period reset of counter, no shadow into registers 1 and 2
// RQ3 - Capture mode: pin is capture input; time stamp loads when enabled
// RQ4 - PWM mode: counter resets when it equals the period value
// RQ5 - PWM mode: shadow registers 3 and 4 load into registers 1 and 2
// RQ6 - PWM mode: no time stamps loaded; pin drives the PWM output
// RQ7 - Writing one to soft sync loads phase and pulses sync out when pass
// RQ8 - Writing zero to soft sync does nothing; it always reads zero
// RQ9 - PWM mode: period event also acts as a sync source
// RQ10 - Sync-out field: 00 pass sync-in, 01 period event, else off
// RQ11 - Period sync-out choice also works in capture mode
// RQ12 - Sync-in enable lets sync pulse or soft force load the phase value
// RQ13 - Run bit zero freezes counter, one lets it count
// RQ14 - Bit 0 picks continuous or one-shot capture, capture mode only
// RQ15 - Stop/wrap matches slot counter: freeze, block loads and events
// RQ16 - Re-arm write clears slot counter, unfreezes, enables loads; reads zero
module ccsc_top
  import ccsc_pkg::*;
#(
  parameter int CW = 32
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [ccsc_pkg::CCSC_AW-1:0] addr,
  input wire logic [ccsc_pkg::CCSC_DW-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [ccsc_pkg::CCSC_DW-1:0] rdata,
  input wire logic capture_pwm_pin_in,
  output logic capture_pwm_pin_out,
  output logic capture_pwm_pin_oe_n,
  input wire logic sync_input_pulse,
  output logic sync_out,
  output logic capture_event
);
  import ccsc_pkg::*;

  if (CW != CCSC_DW)
  begin : g_chk
    $error("ccsc_top supports a 32-bit counter only");
  end

  ccsc_bus_t bus;
  ccsc_ctrl_t ctrl_q;
  logic [CW-1:0] timebase_counter_q;
  logic [CW-1:0] phase_offset_reg_q;
  logic [CW-1:0] cap_q [4];
  logic [8:0] ctrl1_q;
  logic [CCSC_DW-1:0] rdata_q;
  logic pin_q;
  logic pwm_q;
  logic sync_out_q;
  logic cap_evt;
  logic count_hits_period;
  logic soft_counter_sync;
  logic oneshot_arm;
  logic phase_load;
  logic wr_ctrl2;
  logic [1:0] slot;
  logic frozen;
  logic load_ok;
  logic aux_pulse_width_mode;
  logic ts_load;
  logic ctr_reset;

  assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
  assign aux_pulse_width_mode = ctrl_q.op_mode_select;
  assign wr_ctrl2 = bus.wr && (bus.addr == OFS_CTRL2);
  // RQ7 soft force strobe
  assign soft_counter_sync = wr_ctrl2 && bus.wdata[B_SOFTSYNC];
  assign oneshot_arm = wr_ctrl2 && bus.wdata[B_ARM];
  assign count_hits_period = (timebase_counter_q == cap_q[0]);

  // RQ12 phase load gate
  assign phase_load = ctrl_q.sync_in_load_enable && (sync_input_pulse || soft_counter_sync);
  // RQ4 period reset only in PWM mode
  assign ctr_reset = aux_pulse_width_mode && count_hits_period;

  // Capture event: rising edge of the pin, capture mode only
  // RQ3 pin as capture input
  assign cap_evt = !aux_pulse_width_mode && capture_pwm_pin_in && !pin_q;
  assign capture_event = cap_evt && !(frozen && ctrl_q.single_run_select);

  // RQ6 no stamps in PWM mode
  // RQ15 loads inhibited when frozen
  assign ts_load = cap_evt && ctrl1_q[B_LDEN] && load_ok;

  ccsc_slot_counter u_slot (
    .clk(clk),
    .rst(rst),
    .event_in(cap_evt),
    .arm(oneshot_arm),
    // RQ14 one-shot only in capture
    .single(ctrl_q.single_run_select && !aux_pulse_width_mode),
    .stop_wrap(ctrl_q.stop_wrap),
    .slot(slot),
    .frozen(frozen),
    .load_ok(load_ok)
  );

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pin_q <= 1'b0;
    else
      pin_q <= capture_pwm_pin_in;
  end

  // Control register two
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ctrl_q <= '{pwm_out_polarity: CTRL2_RST[B_POL], op_mode_select: CTRL2_RST[B_MODE],
        sync_out_source: ccsc_synco_t'(CTRL2_RST[B_SYNCO_LO +: 2]),
        sync_in_load_enable: CTRL2_RST[B_SYNCIN], timebase_run: CTRL2_RST[B_RUN],
        stop_wrap: CTRL2_RST[B_WRAP_LO +: 2], single_run_select: CTRL2_RST[B_SINGLE]};
    else if (wr_ctrl2)
    begin
      ctrl_q.pwm_out_polarity <= bus.wdata[B_POL];
      ctrl_q.op_mode_select <= bus.wdata[B_MODE];
      ctrl_q.sync_out_source <= ccsc_synco_t'(bus.wdata[B_SYNCO_LO +: 2]);
      ctrl_q.sync_in_load_enable <= bus.wdata[B_SYNCIN];
      ctrl_q.timebase_run <= bus.wdata[B_RUN];
      ctrl_q.stop_wrap <= bus.wdata[B_WRAP_LO +: 2];
      ctrl_q.single_run_select <= bus.wdata[B_SINGLE];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ctrl1_q <= 9'h000;
    else if (bus.wr && (bus.addr == OFS_CTRL1))
      ctrl1_q <= bus.wdata[8:0];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      phase_offset_reg_q <= '0;
    else if (bus.wr && (bus.addr == OFS_PHASE))
      phase_offset_reg_q <= bus.wdata;
  end

  // Time-base counter
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      timebase_counter_q <= '0;
    // RQ12 load from phase
    else if (phase_load)
      timebase_counter_q <= phase_offset_reg_q;
    else if (bus.wr && (bus.addr == OFS_COUNTER))
      timebase_counter_q <= bus.wdata;
    // RQ2 no period reset in capture
    else if (ctr_reset)
      timebase_counter_q <= '0;
    // RQ13 run or freeze
    else if (ctrl_q.timebase_run)
      timebase_counter_q <= timebase_counter_q + 1'b1;
  end

  // Capture / period / compare registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 4; i++)
        cap_q[i] <= '0;
    end
    else
    begin
      if (ts_load)
        cap_q[slot] <= timebase_counter_q;
      // RQ5 shadow into active at period boundary
      if (aux_pulse_width_mode && count_hits_period)
      begin
        cap_q[0] <= cap_q[2];
        cap_q[1] <= cap_q[3];
      end
      if (bus.wr && (bus.addr >= OFS_CAPTURE_REG_1) && (bus.addr <= OFS_CAPTURE_REG_4))
        cap_q[2'(bus.addr - OFS_CAPTURE_REG_1)] <= bus.wdata;
    end
  end

  // PWM output, high until compare match then low
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pwm_q <= 1'b0;
    else if (ctr_reset)
      pwm_q <= 1'b1;
    else if (timebase_counter_q == cap_q[1])
      pwm_q <= 1'b0;
  end

  // RQ1 polarity in PWM mode
  assign capture_pwm_pin_out = pwm_q ^ ctrl_q.pwm_out_polarity;
  // RQ6 pin driven only in PWM mode
  assign capture_pwm_pin_oe_n = !aux_pulse_width_mode;

  // Sync-out selection
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sync_out_q <= 1'b0;
    else
    begin
      unique case (ctrl_q.sync_out_source)
        // RQ10 pass sync-in or soft force
        SYNCO_PASS: sync_out_q <= sync_input_pulse || soft_counter_sync;
        // RQ11 period event any mode
        // RQ9 period as sync source
        SYNCO_PRD: sync_out_q <= count_hits_period;
        SYNCO_OFF2: sync_out_q <= 1'b0;
        SYNCO_OFF3: sync_out_q <= 1'b0;
      endcase
    end
  end
  assign sync_out = sync_out_q;

  // Read data, one cycle after the strobe
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata_q <= '0;
    else if (bus.rd)
    begin
      unique case (bus.addr)
        // RQ8 soft sync reads zero
        // RQ16 re-arm reads zero
        OFS_CTRL2: rdata_q <= {21'h0, ctrl_q.pwm_out_polarity, ctrl_q.op_mode_select, 1'b0,
          ctrl_q.sync_out_source, ctrl_q.sync_in_load_enable, ctrl_q.timebase_run, 1'b0,
          ctrl_q.stop_wrap, ctrl_q.single_run_select};
        OFS_COUNTER: rdata_q <= timebase_counter_q;
        OFS_PHASE: rdata_q <= phase_offset_reg_q;
        OFS_CAPTURE_REG_1: rdata_q <= cap_q[0];
        OFS_CAPTURE_REG_2: rdata_q <= cap_q[1];
        OFS_CAPTURE_REG_3: rdata_q <= cap_q[2];
        OFS_CAPTURE_REG_4: rdata_q <= cap_q[3];
        OFS_CTRL1: rdata_q <= {23'h0, ctrl1_q};
        default: rdata_q <= '0;
      endcase
    end
    else
      rdata_q <= '0;
  end
  assign rdata = rdata_q;

  property p_period_reset;
    @(posedge clk) disable iff (rst)
    (aux_pulse_width_mode && count_hits_period && !phase_load && !bus.wr) |=> timebase_counter_q == 0;
  endproperty
  a_period_reset: assert property (p_period_reset) else $error("no period reset"); // RQ4

  property p_no_reset_cap;
    @(posedge clk) disable iff (rst)
    (!aux_pulse_width_mode && ctrl_q.timebase_run && !phase_load && !bus.wr)
      |=> timebase_counter_q == $past(timebase_counter_q) + 1;
  endproperty
  a_no_reset_cap: assert property (p_no_reset_cap) else $error("capture count wrong"); // RQ2

  property p_freeze;
    @(posedge clk) disable iff (rst)
    (!ctrl_q.timebase_run && !phase_load && !bus.wr && !ctr_reset) |=> $stable(timebase_counter_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("counter moved while stopped"); // RQ13

  property p_phase;
    @(posedge clk) disable iff (rst)
    phase_load |=> timebase_counter_q == $past(phase_offset_reg_q);
  endproperty
  a_phase: assert property (p_phase) else $error("phase not loaded"); // RQ12

  property p_softsync_read;
    @(posedge clk) disable iff (rst)
    (bus.rd && bus.addr == OFS_CTRL2) |=> (rdata[B_SOFTSYNC] == 1'b0 && rdata[B_ARM] == 1'b0);
  endproperty
  a_softsync_read: assert property (p_softsync_read) else $error("strobe bit read nonzero"); // RQ8

  property p_synco_off;
    @(posedge clk) disable iff (rst)
    ctrl_q.sync_out_source[1] |=> !sync_out;
  endproperty
  a_synco_off: assert property (p_synco_off) else $error("sync out not disabled"); // RQ10

  property p_soft_pass;
    @(posedge clk) disable iff (rst)
    (soft_counter_sync && ctrl_q.sync_out_source == SYNCO_PASS) |=> sync_out;
  endproperty
  a_soft_pass: assert property (p_soft_pass) else $error("soft sync not passed"); // RQ7

  property p_pwm_nostamp;
    @(posedge clk) disable iff (rst)
    aux_pulse_width_mode |-> !ts_load && !capture_pwm_pin_oe_n;
  endproperty
  a_pwm_nostamp: assert property (p_pwm_nostamp) else $error("stamp in pwm mode"); // RQ6

  property p_polarity;
    @(posedge clk) disable iff (rst)
    (ctr_reset && !wr_ctrl2) |=> capture_pwm_pin_out == !ctrl_q.pwm_out_polarity;
  endproperty
  a_polarity: assert property (p_polarity) else $error("pwm period start level wrong"); // RQ1

  property p_pass_syncin;
    @(posedge clk) disable iff (rst)
    (sync_input_pulse && ctrl_q.sync_out_source == SYNCO_PASS) |=> sync_out;
  endproperty
  a_pass_syncin: assert property (p_pass_syncin) else $error("sync in not passed"); // RQ10

  property p_period_out;
    @(posedge clk) disable iff (rst)
    (count_hits_period && ctrl_q.sync_out_source == SYNCO_PRD) |=> sync_out;
  endproperty
  a_period_out: assert property (p_period_out) else $error("period sync out missing"); // RQ11

  property p_sync_ignored;
    @(posedge clk) disable iff (rst)
    (!ctrl_q.sync_in_load_enable && (sync_input_pulse || soft_counter_sync) && !ctr_reset
      && !(bus.wr && bus.addr == OFS_COUNTER))
      |=> timebase_counter_q == $past(timebase_counter_q) + {31'h0, $past(ctrl_q.timebase_run)};
  endproperty
  a_sync_ignored: assert property (p_sync_ignored) else $error("load without enable"); // RQ12

  property p_stamp;
    @(posedge clk) disable iff (rst)
    (ts_load && !(bus.wr && bus.addr >= OFS_CAPTURE_REG_1 && bus.addr <= OFS_CAPTURE_REG_4))
      |=> cap_q[$past(slot)] == $past(timebase_counter_q);
  endproperty
  a_stamp: assert property (p_stamp) else $error("time stamp not stored"); // RQ3

  property p_shadow;
    @(posedge clk) disable iff (rst)
    (aux_pulse_width_mode && count_hits_period && !bus.wr)
      |=> cap_q[0] == $past(cap_q[2]) && cap_q[1] == $past(cap_q[3]);
  endproperty
  a_shadow: assert property (p_shadow) else $error("shadow not transferred"); // RQ5

  property p_cap_hold;
    @(posedge clk) disable iff (rst)
    (!aux_pulse_width_mode && !ts_load && !bus.wr) |=> $stable(cap_q[0]) && $stable(cap_q[1]);
  endproperty
  a_cap_hold: assert property (p_cap_hold) else $error("shadow moved in capture mode"); // RQ2

  property p_frozen_block;
    @(posedge clk) disable iff (rst)
    (frozen && ctrl_q.single_run_select) |-> !ts_load && !capture_event;
  endproperty
  a_frozen_block: assert property (p_frozen_block) else $error("load while frozen"); // RQ15

  property p_oneshot_arm;
    @(posedge clk) disable iff (rst)
    oneshot_arm |=> !frozen && slot == 2'h0;
  endproperty
  a_oneshot_arm: assert property (p_oneshot_arm) else $error("re-arm did not clear"); // RQ16
endmodule

// ==== testbench/ccsc_far_model.sv ====
`timescale 1ns/1ns
module ccsc_far_model
(
  input wire logic clk,
  input wire logic fire,
  input wire logic pin_lvl,
  input wire logic pin_out,
  input wire logic pin_oe_n,
  input wire logic sync_out,
  output logic sync_pulse,
  output int sync_seen,
  output logic pin_in
);
  initial sync_pulse = 1'b0;
  initial sync_seen = 0;
  // One-cycle sync pulse from the upstream neighbour
  always @(posedge clk)
    sync_pulse <= fire;
  // Downstream neighbour loads once per sync-out pulse
  always @(posedge clk)
    if (sync_out === 1'b1)
      sync_seen <= sync_seen + 1;
  // Wire level: the module owns the pin while its enable is low
  assign pin_in = (pin_oe_n === 1'b0) ? pin_out : pin_lvl;
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  import ccsc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic fire = 1'b0;
  logic pin_lvl = 1'b0;
  logic [31:0] rdata;
  logic pin_in, pin_out, pin_oe_n, sync_pulse, sync_out;
  int sync_seen;
  int errors = 0;
  int comparisons = 0;
  logic cap_ev;
  int ev_cnt = 0;

  ccsc_top uut
  (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .capture_pwm_pin_in(pin_in), .capture_pwm_pin_out(pin_out),
    .capture_pwm_pin_oe_n(pin_oe_n), .sync_input_pulse(sync_pulse),
    .sync_out(sync_out), .capture_event(cap_ev)
  );

  ccsc_far_model far
  (
    .clk(clk), .fire(fire), .pin_lvl(pin_lvl), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .sync_out(sync_out), .sync_pulse(sync_pulse),
    .sync_seen(sync_seen), .pin_in(pin_in)
  );

  // Qualified capture events seen on the output
  always @(posedge clk)
    if (cap_ev === 1'b1)
      ev_cnt <= ev_cnt + 1;

  initial
    forever #50 clk = ~clk;

  task automatic print_verdict();
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, m, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
  endtask

  task automatic pin_edge();
    pin_lvl <= 1'b1;
    repeat (3) @(posedge clk);
    pin_lvl <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Cycles until the next sync-out pulse, bounded
  task automatic wait_sync(output int n);
    int s0;
    s0 = sync_seen;
    n = 0;
    while (sync_seen == s0 && n < 60)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 60)
    begin
      errors++;
      print_verdict();
    end
  endtask

  task automatic hi_cnt(output int h);
    h = 0;
    repeat (10)
    begin
      @(posedge clk);
      if (pin_out === 1'b1)
        h++;
    end
  endtask

  initial
  begin
    logic [31:0] v, a;
    int s0, n, h0, h1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_reg(OFS_CTRL2, v);
    check(v, 32'h0000_0006, "ctrl2 reset");
    check({31'h0, pin_oe_n}, 32'h1, "pin idle");
    $display("test reset done");

    wr_reg(OFS_PHASE, 32'h0000_0100);
    wr_reg(OFS_CTRL2, 32'h0000_0100);
    rd_reg(OFS_COUNTER, v);
    check(v, 32'h0, "load without enable");
    wr_reg(OFS_CTRL2, 32'h0000_0020);
    s0 = sync_seen;
    wr_reg(OFS_CTRL2, 32'h0000_0120);
    rd_reg(OFS_COUNTER, v);
    check(v, 32'h0000_0100, "soft load");
    check(sync_seen - s0, 32'h1, "soft pass");
    rd_reg(OFS_CTRL2, v);
    check(v, 32'h0000_0020, "soft bit reads 0");
    wr_reg(OFS_PHASE, 32'h0000_0055);
    wr_reg(OFS_CTRL2, 32'h0000_0020);
    rd_reg(OFS_COUNTER, v);
    check(v, 32'h0000_0100, "zero write");
    $display("test soft sync done");

    rd_reg(OFS_COUNTER, a);
    check(a, 32'h0000_0100, "frozen");
    wr_reg(OFS_CTRL2, 32'h0000_0030);
    rd_reg(OFS_COUNTER, a);
    rd_reg(OFS_COUNTER, v);
    check(v - a, 32'h2, "running");
    $display("test run done");

    for (int m = 0; m < 4; m++)
    begin
      wr_reg(OFS_CTRL2, 32'h0000_0020 | (m << 6));
      s0 = sync_seen;
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      repeat (4) @(posedge clk);
      check(sync_seen - s0, {31'h0, m == 0}, "sync out select");
    end
    rd_reg(OFS_COUNTER, v);
    check(v, 32'h0000_0055, "ext load");
    $display("test sync in done");

    wr_reg(OFS_CAPTURE_REG_1, 32'h0000_0005);
    wr_reg(OFS_PHASE, 32'h0);
    wr_reg(OFS_CTRL2, 32'h0000_0120);
    s0 = sync_seen;
    wr_reg(OFS_CTRL2, 32'h0000_0070);
    repeat (20) @(posedge clk);
    rd_reg(OFS_COUNTER, v);
    check({31'h0, v > 32'h5}, 32'h1, "no period reset");
    check(sync_seen - s0, 32'h1, "period sync out");
    $display("test capture period done");

    wr_reg(OFS_CTRL1, 32'h0000_0100);
    wr_reg(OFS_CAPTURE_REG_2, 32'h0);
    wr_reg(OFS_PHASE, 32'h0000_0077);
    wr_reg(OFS_CTRL2, 32'h0000_0121);
    wr_reg(OFS_CTRL2, 32'h0000_0029);
    pin_edge();
    rd_reg(OFS_CAPTURE_REG_1, v);
    check(v, 32'h0000_0077, "stamp");
    wr_reg(OFS_COUNTER, 32'h0000_0099);
    pin_edge();
    rd_reg(OFS_CAPTURE_REG_1, v);
    check(v, 32'h0000_0077, "stopped");
    check(ev_cnt, 32'd1, "event blocked");
    rd_reg(OFS_CTRL2, v);
    check(v, 32'h0000_0021, "arm reads 0");
    wr_reg(OFS_PHASE, 32'h0000_0088);
    wr_reg(OFS_CTRL2, 32'h0000_0121);
    wr_reg(OFS_CTRL2, 32'h0000_0029);
    pin_edge();
    rd_reg(OFS_CAPTURE_REG_1, v);
    check(v, 32'h0000_0088, "rearmed");
    check(ev_cnt, 32'd2, "event rearmed");
    $display("test one shot done");

    wr_reg(OFS_CTRL2, 32'h0000_002a);
    wr_reg(OFS_COUNTER, 32'h0000_0011);
    pin_edge();
    wr_reg(OFS_COUNTER, 32'h0000_0022);
    pin_edge();
    wr_reg(OFS_COUNTER, 32'h0000_0033);
    pin_edge();
    rd_reg(OFS_CAPTURE_REG_1, v);
    check(v, 32'h0000_0033, "wrap slot");
    rd_reg(OFS_CAPTURE_REG_2, v);
    check(v, 32'h0000_0022, "second slot");
    $display("test continuous done");

    wr_reg(OFS_CAPTURE_REG_1, 32'h0000_0009);
    wr_reg(OFS_CAPTURE_REG_2, 32'h0000_0002);
    wr_reg(OFS_CAPTURE_REG_3, 32'h0000_0009);
    wr_reg(OFS_CAPTURE_REG_4, 32'h0000_0002);
    wr_reg(OFS_COUNTER, 32'h0);
    wr_reg(OFS_CTRL2, 32'h0000_0250);
    check({31'h0, pin_oe_n}, 32'h0, "pin driven");
    wait_sync(n);
    wait_sync(n);
    check(n, 32'd10, "pwm period");
    hi_cnt(h0);
    check(h0, 32'd3, "pwm high time");
    wr_reg(OFS_CTRL2, 32'h0000_0650);
    hi_cnt(h1);
    check(h0 + h1, 32'd10, "polarity");
    wr_reg(OFS_CAPTURE_REG_3, 32'h0000_0013);
    wait_sync(n);
    wait_sync(n);
    wait_sync(n);
    check(n, 32'd20, "shadow period");
    $display("test pwm done");
    print_verdict();
  end
endmodule
